// File: logic/pdu_pkg.sv
// Shared constants, field positions, timing and carrier types of the parallel DMA user port.
// Assumes a single 25 MHz clock and a 32-bit Avalon-MM register bus with byte addressing.
package pdu_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int END_CYCLE_NS = 100;
  localparam int GO_PULSE_NS = 200;
  localparam int SEC_INIT_NS = 200;
  // Least times, rounded up to whole clock cycles
  localparam int END_CYCLE_CYCLES = (END_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GO_PULSE_CYCLES = (GO_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEC_INIT_CYCLES = (SEC_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_WIDTH = 4;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam int ADDR_WIDTH = 5;
  localparam logic [4:0] ADDR_OUT_DATA = 5'h00;
  localparam logic [4:0] ADDR_FUNC_OUT = 5'h04;
  localparam logic [4:0] ADDR_FUNC_IN = 5'h08;
  localparam logic [4:0] ADDR_WORD_COUNT = 5'h0c;
  localparam logic [4:0] ADDR_DATA_PORT = 5'h10;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int FOR_FUNCTION_OUT_ONE_BIT = 0;
  localparam int FOR_FUNCTION_OUT_TWO_BIT = 1;
  localparam int FOR_FUNCTION_OUT_THREE_BIT = 2;
  localparam int FOR_INIT_BIT = 3;
  localparam int FOR_GO_BIT = 4;
  localparam int FIR_STATUS_INPUT_C_BIT = 3;
  localparam int FIR_STATUS_INPUT_B_BIT = 4;
  localparam int FIR_STATUS_INPUT_A_BIT = 5;
  localparam int FIR_READY_BIT = 7;
  localparam int WORD_WIDTH = 16;
  localparam logic [15:0] OUT_DATA_RESET = 16'h0000;
  localparam logic [15:0] WORD_COUNT_RESET = 16'h0000;
  localparam logic [15:0] WORD_COUNT_LAST = 16'hffff;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } pdu_avs_req_type;

  typedef struct packed {
    logic cycleRequestPrimary;
    logic cycleRequestSecondary;
    logic attentionInput;
    logic statusInputA;
    logic statusInputB;
    logic statusInputC;
    logic [15:0] parallelIn;
  } pdu_user_in_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MOVE = 3'b010,
    ST_END = 3'b100
  } pdu_state_type;

endpackage

// File: logic/pdu_fifo.sv
// Small word FIFO with valid/ready on both sides, standing in the DMA data path.
// Assumes one clock and a synchronous active-high reset; read data come from the storage flops.
`timescale 1ns/10ps
module pdu_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("pdu_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtr;
  logic [PW:0] rdPtr;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign inReady = !((wrPtr[PW] != rdPtr[PW]) && (wrPtr[PW-1:0] == rdPtr[PW-1:0]));
  assign outValid = (wrPtr != rdPtr);
  assign outData = mem[rdPtr[PW-1:0]];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr[PW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

endmodule

// File: logic/pdu_parallel_port.sv
// Parallel DMA user port: output lines, cycle requests, end-cycle, ready, init and go pulses.
// Assumes a 25 MHz clock, synchronous active-high host bus reset and an Avalon-MM master.
//
// What this block does
// - Output lines show the last value written to the output data register or the last word popped in an output transfer.
// - A rising cycle request starts a word operation only while ready is low.
// - Second cycle request is OR'ed with the first, same effect.
// - Each completed data cycle gives a high end-of-cycle pulse of 3 clocks (120 ns).
// - Ready sets on bus reset, attention, host bus error during DMA, or a transfer at word count ffff.
// - Writing one to the go bit clears ready.
// - Initialize output is high during bus reset or while its control bit is set.
// - Secondary initialize is high in reset, pulses 200 ns on second function bit set.
// - Word count step input is ignored; count advances on every transfer.
// - First status input reads at function input register bit 5.
// - Second status input reads at function input register bit 4.
// - Third status input reads at function input register bit 3.
// - Data move as 16-bit words between user port and host memory.
// - Go bit write pulses go output 200 ns and drops ready.
// - Second function output follows function output register bit 1.
// - Attention high aborts any transfer in progress and asserts ready.
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
module pdu_parallel_port #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire pdu_pkg::pdu_avs_req_type avsReq,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire pdu_pkg::pdu_user_in_type userIn,
  input wire logic hostBusError,
  output logic [15:0] parallelOut,
  output logic endCycle,
  output logic ready,
  output logic goOut,
  output logic initOut,
  output logic secondaryInitOut,
  output logic functionOutOne,
  output logic functionOutTwo,
  output logic functionOutThree
);
  import pdu_pkg::*;

  // ****************************************************************
  // Parameter check and derived loads
  // ****************************************************************
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("pdu_parallel_port: FIFO_DEPTH must be at least 2");
  end

  localparam logic [PULSE_CNT_WIDTH-1:0] END_LOAD = PULSE_CNT_WIDTH'(END_CYCLE_CYCLES - 1);
  localparam logic [PULSE_CNT_WIDTH-1:0] GO_LOAD = PULSE_CNT_WIDTH'(GO_PULSE_CYCLES - 1);
  localparam logic [PULSE_CNT_WIDTH-1:0] SEC_LOAD = PULSE_CNT_WIDTH'(SEC_INIT_CYCLES - 1);

  // Pulse counters all step down to zero and stay there
  function automatic logic [PULSE_CNT_WIDTH-1:0] countDown(
    input logic [PULSE_CNT_WIDTH-1:0] cnt
  );
    countDown = (cnt != '0) ? cnt - 1'b1 : cnt;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pdu_state_type state;
  logic [1:0] reqASync;
  logic [1:0] reqBSync;
  logic [1:0] attnSync;
  logic reqLast;
  logic cycleReq;
  logic reqRise;
  logic attnLevel;
  logic initBit;
  logic [PULSE_CNT_WIDTH-1:0] endCnt;
  logic [PULSE_CNT_WIDTH-1:0] goCnt;
  logic [PULSE_CNT_WIDTH-1:0] secCnt;
  logic [15:0] wordCount;
  logic dirIn;
  logic access;
  logic accept;
  logic regWrite;
  logic regRead;
  logic goWrite;
  logic secWrite;
  logic busPush;
  logic busPop;
  logic userPush;
  logic userPop;
  logic transfer;
  logic fifoInValid;
  logic fifoInReady;
  logic [15:0] fifoInData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [15:0] fifoOutData;
  logic [31:0] readValue;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Two flops per line; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (reset) begin
      reqASync <= 2'h0;
      reqBSync <= 2'h0;
      attnSync <= 2'h0;
    end else begin
      reqASync <= {reqASync[0], userIn.cycleRequestPrimary};
      reqBSync <= {reqBSync[0], userIn.cycleRequestSecondary};
      attnSync <= {attnSync[0], userIn.attentionInput};
    end
  end

  assign cycleReq = reqASync[1] | reqBSync[1];
  assign attnLevel = attnSync[1];

  always_ff @(posedge clk) begin
    if (reset) begin
      reqLast <= 1'b0;
    end else begin
      reqLast <= cycleReq;
    end
  end

  assign reqRise = cycleReq && !reqLast;

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  // Direction follows the first function bit, as the local control-in line does
  assign dirIn = functionOutOne;
  assign access = (avsReq.read || avsReq.write) && avsWaitrequest;
  // A data port write into a full FIFO is held off, so back-pressure reaches software
  assign accept = access &&
      !(avsReq.write && avsReq.address == ADDR_DATA_PORT && !dirIn && !fifoInReady);
  assign regWrite = accept && avsReq.write;
  assign regRead = accept && avsReq.read;
  assign goWrite = regWrite && avsReq.address == ADDR_FUNC_OUT &&
      avsReq.writedata[FOR_GO_BIT];
  assign secWrite = regWrite && avsReq.address == ADDR_FUNC_OUT &&
      avsReq.writedata[FOR_FUNCTION_OUT_TWO_BIT];
  assign busPush = regWrite && avsReq.address == ADDR_DATA_PORT && !dirIn;
  assign busPop = regRead && avsReq.address == ADDR_DATA_PORT && dirIn && fifoOutValid;

  always_comb begin
    readValue = READ_ZERO;
    case (avsReq.address)
      ADDR_OUT_DATA: begin
        readValue[15:0] = parallelOut;
      end
      ADDR_FUNC_OUT: begin
        readValue[FOR_FUNCTION_OUT_ONE_BIT] = functionOutOne;
        readValue[FOR_FUNCTION_OUT_TWO_BIT] = functionOutTwo;
        readValue[FOR_FUNCTION_OUT_THREE_BIT] = functionOutThree;
        readValue[FOR_INIT_BIT] = initBit;
      end
      ADDR_FUNC_IN: begin
        readValue[FIR_STATUS_INPUT_A_BIT] = userIn.statusInputA;
        readValue[FIR_STATUS_INPUT_B_BIT] = userIn.statusInputB;
        readValue[FIR_STATUS_INPUT_C_BIT] = userIn.statusInputC;
        readValue[FIR_READY_BIT] = ready;
      end
      ADDR_WORD_COUNT: begin
        readValue[15:0] = wordCount;
      end
      ADDR_DATA_PORT: begin
        // Reading an empty FIFO returns zero rather than stalling the bus
        readValue[15:0] = (dirIn && fifoOutValid) ? fifoOutData : 16'h0000;
      end
      default: begin
        readValue = READ_ZERO;
      end
    endcase
  end

  // One wait cycle, then a single low cycle of waitrequest per access
  always_ff @(posedge clk) begin
    if (reset) begin
      avsWaitrequest <= 1'b1;
      avsReaddata <= READ_ZERO;
    end else if (accept) begin
      avsWaitrequest <= 1'b0;
      if (avsReq.read) begin
        avsReaddata <= readValue;
      end
    end else begin
      avsWaitrequest <= 1'b1;
    end
  end

  // ****************************************************************
  // Output data and function bits
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      parallelOut <= OUT_DATA_RESET;
    end else if (regWrite && avsReq.address == ADDR_OUT_DATA) begin
      parallelOut <= avsReq.writedata[15:0];
    end else if (userPop) begin
      parallelOut <= fifoOutData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      functionOutOne <= 1'b0;
      functionOutTwo <= 1'b0;
      functionOutThree <= 1'b0;
      initBit <= 1'b0;
    end else if (regWrite && avsReq.address == ADDR_FUNC_OUT) begin
      functionOutOne <= avsReq.writedata[FOR_FUNCTION_OUT_ONE_BIT];
      functionOutTwo <= avsReq.writedata[FOR_FUNCTION_OUT_TWO_BIT];
      functionOutThree <= avsReq.writedata[FOR_FUNCTION_OUT_THREE_BIT];
      initBit <= avsReq.writedata[FOR_INIT_BIT];
    end
  end

  // Initialize takes the control bit on the same edge as the write, with no lag behind it, and is high in reset
  always_ff @(posedge clk) begin
    if (reset) begin
      initOut <= 1'b1;
    end else if (regWrite && avsReq.address == ADDR_FUNC_OUT) begin
      initOut <= avsReq.writedata[FOR_INIT_BIT];
    end else begin
      initOut <= initBit;
    end
  end

  // ****************************************************************
  // Go and secondary initialize pulses
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      goCnt <= '0;
      goOut <= 1'b0;
    end else if (goWrite) begin
      goCnt <= GO_LOAD;
      goOut <= 1'b1;
    end else begin
      goCnt <= countDown(goCnt);
      goOut <= (goCnt != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      secCnt <= '0;
      secondaryInitOut <= 1'b1;
    end else if (secWrite) begin
      secCnt <= SEC_LOAD;
      secondaryInitOut <= 1'b1;
    end else begin
      secCnt <= countDown(secCnt);
      secondaryInitOut <= (secCnt != '0);
    end
  end

  // ****************************************************************
  // Ready flag
  // ****************************************************************
  // Every set wins over a go write in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      ready <= 1'b1;
    end else if (attnLevel) begin
      ready <= 1'b1;
    end else if (hostBusError && state != ST_IDLE) begin
      ready <= 1'b1;
    end else if (transfer && wordCount == WORD_COUNT_LAST) begin
      ready <= 1'b1;
    end else if (goWrite) begin
      ready <= 1'b0;
    end
  end

  // ****************************************************************
  // Word count
  // ****************************************************************
  // The step input from the user is not even brought in: counting is unconditional
  always_ff @(posedge clk) begin
    if (reset) begin
      wordCount <= WORD_COUNT_RESET;
    end else if (transfer) begin
      wordCount <= wordCount + 16'h0001;
    end else if (regWrite && avsReq.address == ADDR_WORD_COUNT) begin
      wordCount <= avsReq.writedata[15:0];
    end
  end

  // ****************************************************************
  // Word operation sequencer
  // ****************************************************************
  // A word moves once the FIFO can take it or has one to give; until then it waits
  assign transfer = (state == ST_MOVE) && !attnLevel && !hostBusError &&
      (dirIn ? fifoInReady : fifoOutValid);
  assign userPush = transfer && dirIn;
  assign userPop = transfer && !dirIn;

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      endCnt <= '0;
      endCycle <= 1'b0;
    end else if (attnLevel) begin
      state <= ST_IDLE;
      endCnt <= '0;
      endCycle <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          endCycle <= 1'b0;
          if (reqRise && !ready) begin
            state <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (hostBusError) begin
            state <= ST_IDLE;
          end else if (transfer) begin
            state <= ST_END;
            endCnt <= END_LOAD;
            endCycle <= 1'b1;
          end
        end
        ST_END: begin
          endCnt <= countDown(endCnt);
          endCycle <= (endCnt != '0);
          if (endCnt == '0) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          endCnt <= '0;
          endCycle <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Data FIFO
  // ****************************************************************
  // One FIFO serves both directions; switching direction with words left mixes them
  assign fifoInValid = dirIn ? userPush : busPush;
  assign fifoInData = dirIn ? userIn.parallelIn : avsReq.writedata[15:0];
  assign fifoOutReady = dirIn ? busPop : userPop;

  pdu_fifo #(
    .WIDTH(WORD_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

endmodule

// File: verif/pdu_port_monitor.sv
// Concurrent checks on the ports of the parallel DMA user port.
// Assumes one clock, synchronous active-high reset; bound to pdu_parallel_port below.
`timescale 1ns/10ps
module pdu_port_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire pdu_pkg::pdu_avs_req_type avsReq,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire pdu_pkg::pdu_user_in_type userIn,
  input wire logic hostBusError,
  input wire logic [15:0] parallelOut,
  input wire logic endCycle,
  input wire logic ready,
  input wire logic goOut,
  input wire logic initOut,
  input wire logic secondaryInitOut,
  input wire logic functionOutOne,
  input wire logic functionOutTwo,
  input wire logic functionOutThree
);
  import pdu_pkg::*;
  // ****************************************************************
  // Accepted accesses
  // ****************************************************************
  logic fnWr;
  logic outWr;
  logic inRd;
  // An access is taken on the edge where waitrequest is still high
  assign fnWr = avsReq.write && avsWaitrequest && avsReq.address == ADDR_FUNC_OUT;
  assign outWr = avsReq.write && avsWaitrequest && avsReq.address == ADDR_OUT_DATA;
  assign inRd = avsReq.read && avsWaitrequest && avsReq.address == ADDR_FUNC_IN;
  default clocking cb @(posedge clk); endclocking
  // ****************************************************************
  // Properties
  // ****************************************************************
  // Reset needs no disable: it is the cause here
  property p_reset_out;
    reset |=> ready && initOut && secondaryInitOut;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");
  property p_out_data;
    disable iff (reset) outWr |=> parallelOut == $past(avsReq.writedata[15:0]);
  endproperty
  a_out_data: assert property (p_out_data) else $error("output lines wrong");
  property p_fn_out;
    disable iff (reset)
    fnWr |=> {functionOutThree, functionOutTwo, functionOutOne} == $past(avsReq.writedata[2:0]);
  endproperty
  a_fn_out: assert property (p_fn_out) else $error("function outputs wrong");
  property p_init;
    disable iff (reset) fnWr |=> initOut == $past(avsReq.writedata[FOR_INIT_BIT]);
  endproperty
  a_init: assert property (p_init) else $error("initialize output wrong");
  property p_sec_init;
    disable iff (reset)
    fnWr && avsReq.writedata[FOR_FUNCTION_OUT_TWO_BIT] |=> secondaryInitOut [*5] ##1 !secondaryInitOut;
  endproperty
  a_sec_init: assert property (p_sec_init) else $error("secondary init pulse wrong");
  property p_go;
    disable iff (reset) fnWr && avsReq.writedata[FOR_GO_BIT] |=> goOut [*5] ##1 !goOut;
  endproperty
  a_go: assert property (p_go) else $error("go pulse wrong");
  property p_go_ready;
    disable iff (reset)
    fnWr && avsReq.writedata[FOR_GO_BIT] && !userIn.attentionInput |=> !ready;
  endproperty
  a_go_ready: assert property (p_go_ready) else $error("ready not cleared by go");
  property p_end_len;
    disable iff (reset) $rose(endCycle) && !userIn.attentionInput |-> endCycle [*3] ##1 !endCycle;
  endproperty
  a_end_len: assert property (p_end_len) else $error("end cycle pulse length wrong");
  property p_end_ready;
    disable iff (reset) $rose(endCycle) |-> !$past(ready);
  endproperty
  a_end_ready: assert property (p_end_ready) else $error("transfer while ready high");
  property p_attention_input;
    disable iff (reset) userIn.attentionInput [*4] |-> ready && !endCycle;
  endproperty
  a_attention_input: assert property (p_attention_input) else $error("attention did not set ready");
  property p_status;
    disable iff (reset)
    inRd |=> avsReaddata[5:3] == $past({userIn.statusInputA, userIn.statusInputB,
                                        userIn.statusInputC});
  endproperty
  a_status: assert property (p_status) else $error("status bits wrong");
endmodule
bind pdu_parallel_port pdu_port_monitor i_pdu_port_monitor (
  .clk(clk),
  .reset(reset),
  .avsReq(avsReq),
  .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest),
  .userIn(userIn),
  .hostBusError(hostBusError),
  .parallelOut(parallelOut),
  .endCycle(endCycle),
  .ready(ready),
  .goOut(goOut),
  .initOut(initOut),
  .secondaryInitOut(secondaryInitOut),
  .functionOutOne(functionOutOne),
  .functionOutTwo(functionOutTwo),
  .functionOutThree(functionOutThree)
);

// File: verif/pdu_user_model.sv
// Behavioural user equipment on the far side of the parallel port.
// Assumes the bench calls its tasks and that ready comes from the port.
`timescale 1ns/10ps
module pdu_user_model (
  input wire logic clk,
  input wire logic ready,
  output pdu_pkg::pdu_user_in_type userIn
);
  import pdu_pkg::*;
  initial userIn = '0;
  // ****************************************************************
  // Requests
  // ****************************************************************
  // Held long enough for a whole end cycle; anyway breaks the ready rule on command
  task request(input logic useB, input logic anyway, input logic [15:0] word);
    @(posedge clk);
    userIn.parallelIn <= word;
    if (ready === 1'b0 || anyway) begin
      if (useB) userIn.cycleRequestSecondary <= 1'b1;
      else userIn.cycleRequestPrimary <= 1'b1;
    end
    repeat (10) @(posedge clk);
    userIn.cycleRequestPrimary <= 1'b0;
    userIn.cycleRequestSecondary <= 1'b0;
    @(posedge clk);
  endtask
  task attention(input int n);
    @(posedge clk);
    userIn.attentionInput <= 1'b1;
    repeat (n) @(posedge clk);
    userIn.attentionInput <= 1'b0;
  endtask
  task set_status(input logic [2:0] s);
    @(posedge clk);
    userIn.statusInputA <= s[2];
    userIn.statusInputB <= s[1];
    userIn.statusInputC <= s[0];
  endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for the parallel DMA user port.
// Assumes the user model and the bound monitor; Avalon master tasks live here.
`timescale 1ns/10ps
module tb;
  import pdu_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  pdu_avs_req_type avsReq = '0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic hostBusError = 1'b0;
  pdu_user_in_type userIn;
  logic [15:0] parallelOut;
  logic endCycle, ready, goOut, initOut, secondaryInitOut;
  logic functionOutOne, functionOutTwo, functionOutThree;
  logic [2:0] pl;
  logic [31:0] rd;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int nEnd = 0;
  int run [3] = '{default: 0};
  int last [3] = '{default: 0};
  always #20 clk = ~clk;
  pdu_parallel_port i_pdu_parallel_port (.clk(clk), .reset(reset), .avsReq(avsReq),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .userIn(userIn),
    .hostBusError(hostBusError), .parallelOut(parallelOut), .endCycle(endCycle),
    .ready(ready), .goOut(goOut), .initOut(initOut), .secondaryInitOut(secondaryInitOut),
    .functionOutOne(functionOutOne), .functionOutTwo(functionOutTwo),
    .functionOutThree(functionOutThree));
  pdu_user_model u_user (.clk(clk), .ready(ready), .userIn(userIn));
  // ****************************************************************
  // Pulse lengths and timeout
  // ****************************************************************
  assign pl = {endCycle, goOut, secondaryInitOut};
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 3; k++) begin
      if (pl[k] === 1'b1) run[k] <= run[k] + 1;
      else begin
        if (run[k] != 0) last[k] <= run[k];
        if (run[k] != 0 && k == 2) nEnd <= nEnd + 1;
        run[k] <= 0;
      end
    end
    if (cyc == 20000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  // ****************************************************************
  // Common tasks
  // ****************************************************************
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Held until waitrequest is seen low; only the global timeout ends a hang
  task bw(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avsReq <= {1'b0, 1'b1, a, d};
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    avsReq <= '0;
  endtask
  task br(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avsReq <= {1'b1, 1'b0, a, 32'h0000_0000};
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    d = avsReaddata;
    avsReq <= '0;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    chk("ready", ready, 32'h1);
    u_user.request(1'b0, 1'b1, 16'h0000);
    chk("endCount", nEnd, 32'h0);
    $display("test reset done");
  endtask
  task t_regs;
    bw(ADDR_OUT_DATA, 32'h0000_a5c3);
    chk("parallelOut", parallelOut, 32'h0000_a5c3);
    br(5'h1c, rd);
    chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      u_user.set_status(3'b100 >> i);
      repeat (2) @(posedge clk);
      br(ADDR_FUNC_IN, rd);
      chk("status", rd[5:3], 32'(3'b100 >> i));
    end
    $display("test registers done");
  endtask
  task t_func;
    bw(ADDR_FUNC_OUT, 32'h0000_000d);
    chk("fn", {initOut, functionOutThree, functionOutTwo, functionOutOne}, 32'hd);
    bw(ADDR_FUNC_OUT, 32'h0000_0002);
    repeat (8) @(posedge clk);
    chk("secInitLen", last[0], 32'h5);
    chk("init", initOut, 32'h0);
    bw(ADDR_FUNC_OUT, 32'h0000_0010);
    repeat (8) @(posedge clk);
    chk("goLen", last[1], 32'h5);
    chk("ready", ready, 32'h0);
    $display("test function outputs done");
  endtask
  task t_out;
    for (int i = 0; i < 4; i++) bw(ADDR_DATA_PORT, 32'hc000 + i);
    // A fifth word must wait until the user side pops one
    fork
      bw(ADDR_DATA_PORT, 32'h0000_c004);
      begin
        repeat (4) @(posedge clk);
        #1 chk("fullHold", avsWaitrequest, 32'h1);
        u_user.request(1'b0, 1'b0, 16'h0000);
      end
    join
    chk("endLen", last[2], 32'h3);
    chk("word0", parallelOut, 32'h0000_c000);
    for (int i = 1; i < 5; i++) begin
      u_user.request(i[0], 1'b0, 16'h0000);
      chk("word", parallelOut, 32'hc000 + i);
    end
    br(ADDR_WORD_COUNT, rd);
    chk("wordCount", rd, 32'h5);
    $display("test output transfers done");
  endtask
  task t_abort;
    u_user.request(1'b0, 1'b0, 16'h0000);
    @(posedge clk);
    hostBusError <= 1'b1;
    @(posedge clk);
    hostBusError <= 1'b0;
    repeat (2) @(posedge clk);
    chk("readyBusErr", ready, 32'h1);
    bw(ADDR_FUNC_OUT, 32'h0000_0010);
    u_user.request(1'b1, 1'b0, 16'h0000);
    u_user.attention(5);
    @(posedge clk);
    chk("readyAttn", ready, 32'h1);
    chk("endCount", nEnd, 32'h5);
    $display("test abort done");
  endtask
  task t_in;
    bw(ADDR_FUNC_OUT, 32'h0000_0011);
    u_user.request(1'b0, 1'b0, 16'h5a01);
    // Count wraps on the next word, which must raise ready
    bw(ADDR_WORD_COUNT, 32'h0000_ffff);
    u_user.request(1'b1, 1'b0, 16'h5a02);
    chk("readyCountEnd", ready, 32'h1);
    br(ADDR_DATA_PORT, rd);
    chk("in0", rd, 32'h0000_5a01);
    br(ADDR_DATA_PORT, rd);
    chk("in1", rd, 32'h0000_5a02);
    br(ADDR_DATA_PORT, rd);
    chk("inEmpty", rd, 32'h0);
    $display("test input transfers done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_func();
    t_out();
    t_abort();
    t_in();
    give_verdict();
  end
endmodule
